// File: verilog/led_pkg.sv
// Purpose: shared constants and types for the led driver serial control block
// Assumes: 10 MHz system clock; two-wire target with one fixed address
// Notes: register indices are the internal addresses seen on the serial bus
`default_nettype none
package led_pkg;
    // internal register indices and power-on values
    localparam logic [7:0] IDX_GENERAL = 8'h10;
    localparam logic [7:0] IDX_MAIN = 8'ha0;
    localparam logic [7:0] IDX_AUX = 8'hc0;
    localparam logic [7:0] GENERAL_RST = 8'h20;
    localparam logic [7:0] MAIN_RST = 8'he0;
    localparam logic [7:0] AUX_RST = 8'hfc;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // general control field positions
    localparam int GC_MAIN_EN_BIT = 0;
    localparam int GC_TEST0_BIT = 1;
    localparam int GC_AUX_EN_BIT = 2;
    localparam int GC_SENSE5_BIT = 5;
    localparam int GC_TEST1_BIT = 6;

    // brightness fields sit in the low bits
    localparam int MAIN_CODE_W = 5;
    localparam int AUX_CODE_W = 2;
    localparam int NUM_MAIN_SINKS = 5;

    // serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'd8;

    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int PWM_FREQ_HZ = 20_000;
    localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
    localparam int DUTY_STEPS = 16;

    typedef enum logic [1:0] {CUR_20, CUR_40, CUR_70, CUR_100} cur_e;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_INDEX, ST_DATA, ST_READ, ST_IGNORE} link_st_e;
endpackage
`default_nettype wire

// File: verilog/bit_link_if.sv
// Purpose: carries each sampled serial bit from the scl domain to the clk domain
// Assumes: tgl flips once per scl rising edge, bitv stable until the next one
// Notes: bitv is only read after tgl has passed a two-stage synchroniser
`timescale 1ns/100ps
`default_nettype none
interface bit_link_if;
    logic tgl;
    logic bitv;
    modport src (output tgl, output bitv);
    modport dst (input tgl, input bitv);
endinterface
`default_nettype wire

// File: verilog/scl_bit_capture.sv
// Purpose: samples the data line on every scl rising edge in the scl domain
// Assumes: scl stands still between frames; data is stable while scl is high
// Notes: the bit is held a full scl period, far longer than the crossing delay
`timescale 1ns/100ps
`default_nettype none
module scl_bit_capture import led_pkg::*; (
    input wire logic scl,
    input wire logic rstn,
    input wire logic sda_in,
    bit_link_if.src link
);
    typedef struct packed {
        logic tgl;
        logic bitv;
    } cap_s;

    cap_s r_ff;
    cap_s nxt_r;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.tgl = ~r_ff.tgl;
        nxt_r.bitv = sda_in;
    end

    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign link.tgl = r_ff.tgl;
    assign link.bitv = r_ff.bitv;
endmodule
`default_nettype wire

// File: verilog/led_driver_serial_control.sv
// Purpose: serial target, control registers, pwm and pump gain choice of an led driver
// Assumes: scl is the link clock; data line is open drain; inputs from pins are async
// Notes: bit sampling runs on scl, framing and everything else on clk
// Behaviour
// - data changes only while scl low
// - bus busy from start until stop
// - repeated start restarts address reception
// - eight bits msb first, then ack
// - pull data low through ninth pulse
// - first byte: address plus direction bit
// - answer only to fixed target address
// - write: index byte, then data byte
// - index 10h general control, reset 20h
// - index a0h main brightness, reset e0h
// - index c0h aux brightness, reset fch
// - separate main and aux enable bits
// - sense bit includes fifth sink monitoring
// - hardware reset restores registers, disables driver
// - pass gain, 1.5x on low headroom
// - gain watches enabled main sinks only
// - 32 main steps, 4 aux steps
// - codes in low bits, all ones full
// - main pwm fixed at 20 khz
// - main code to current and duty map
// - aux codes select 20/40/70/100 percent
`timescale 1ns/100ps
`default_nettype none
module led_driver_serial_control import led_pkg::*; #(
    // arbitrary value, not any real part's address
    parameter logic [6:0] TARGET_ADDR = 7'h2a,
    parameter int PWM_PERIOD = PWM_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic hw_reset_n,
    input wire logic [NUM_MAIN_SINKS-1:0] headroom_low,
    output logic [NUM_MAIN_SINKS-1:0] main_sink_on,
    output logic [1:0] main_current_sel,
    output logic aux_sink_on,
    output logic [1:0] aux_current_sel,
    output logic pump_gain_high,
    output logic bus_busy,
    output logic test_bit_zero,
    output logic test_bit_one
);
    localparam int PW = $clog2(PWM_PERIOD);

    if (PWM_PERIOD < DUTY_STEPS) begin : g_bad_period
        $error("pwm period shorter than the number of duty steps");
    end

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [1:0] tgl_s;
        logic [1:0] hw_s;
        logic [NUM_MAIN_SINKS-1:0] hr_s1;
        logic [NUM_MAIN_SINKS-1:0] hr_s2;
        logic scl_prev;
        logic sda_prev;
        logic tgl_prev;
        link_st_e state;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] index;
        logic [7:0] tx;
        logic ack_pending;
        logic oe;
        logic [7:0] gc;
        logic [7:0] mb;
        logic [7:0] ab;
        logic gain_high;
        logic [PW-1:0] pwm_cnt;
        logic pwm_on;
        logic [1:0] cur_sel;
    } st_s;

    localparam st_s ST_RST = '{
        scl_s: 2'h3, sda_s: 2'h3, tgl_s: 2'h0, hw_s: 2'h0,
        hr_s1: '0, hr_s2: '0, scl_prev: 1'b1, sda_prev: 1'b1, tgl_prev: 1'b0,
        state: ST_IDLE, bitcnt: 4'h0, shreg: 8'h00, index: 8'h00, tx: 8'h00,
        ack_pending: 1'b0, oe: 1'b0, gc: GENERAL_RST, mb: MAIN_RST, ab: AUX_RST,
        gain_high: 1'b0, pwm_cnt: '0, pwm_on: 1'b0, cur_sel: 2'h0
    };

    st_s r_ff;
    st_s nxt_r;

    bit_link_if link ();

    scl_bit_capture u_capture (
        .scl(scl),
        .rstn(rstn),
        .sda_in(sda_in),
        .link(link)
    );

    // main code to current level and duty numerator (out of 16)
    function automatic logic [6:0] main_map(input logic [MAIN_CODE_W-1:0] code);
        logic [1:0] cur;
        logic [4:0] duty;
        cur = CUR_20;
        duty = 5'h00;
        if (code < 5'h10) begin
            cur = CUR_20;
            duty = code + 5'h01;
        end else if (code < 5'h17) begin
            cur = CUR_40;
            duty = code - 5'h06;
        end else if (code < 5'h1d) begin
            cur = CUR_70;
            duty = code - 5'h0c;
        end else if (code == 5'h1d) begin
            cur = CUR_100;
            duty = 5'h0d;
        end else if (code == 5'h1e) begin
            cur = CUR_100;
            duty = 5'h0f;
        end else begin
            cur = CUR_100;
            duty = 5'h10;
        end
        return {cur, duty};
    endfunction

    logic scl_fall;
    logic start_evt;
    logic stop_evt;
    logic bit_evt;
    logic bit_now;
    logic hw_ok;
    logic [7:0] byte_in;
    logic [7:0] read_val;
    logic [6:0] mapped;
    logic [NUM_MAIN_SINKS-1:0] monitored;

    always_comb begin
        nxt_r = r_ff;
        // first stages feed only the second stages
        nxt_r.scl_s = {r_ff.scl_s[0], scl};
        nxt_r.sda_s = {r_ff.sda_s[0], sda_in};
        nxt_r.tgl_s = {r_ff.tgl_s[0], link.tgl};
        nxt_r.hw_s = {r_ff.hw_s[0], hw_reset_n};
        nxt_r.hr_s1 = headroom_low;
        nxt_r.hr_s2 = r_ff.hr_s1;
        nxt_r.scl_prev = r_ff.scl_s[1];
        nxt_r.sda_prev = r_ff.sda_s[1];
        nxt_r.tgl_prev = r_ff.tgl_s[1];

        hw_ok = r_ff.hw_s[1];
        scl_fall = r_ff.scl_prev && !r_ff.scl_s[1];
        // start/stop: data edge while scl held high across both samples
        start_evt = r_ff.scl_prev && r_ff.scl_s[1] && r_ff.sda_prev && !r_ff.sda_s[1];
        stop_evt = r_ff.scl_prev && r_ff.scl_s[1] && !r_ff.sda_prev && r_ff.sda_s[1];
        // bitv is stable for a whole scl period once the toggle is seen
        bit_evt = r_ff.tgl_s[1] != r_ff.tgl_prev;
        bit_now = link.bitv;
        byte_in = {r_ff.shreg[6:0], bit_now};

        unique case (r_ff.index)
            IDX_GENERAL: read_val = r_ff.gc;
            IDX_MAIN: read_val = r_ff.mb;
            IDX_AUX: read_val = r_ff.ab;
            default: read_val = UNMAPPED_READ;
        endcase

        if (bit_evt && r_ff.state != ST_IDLE && r_ff.state != ST_IGNORE) begin
            if (r_ff.bitcnt < BITS_PER_BYTE) begin
                nxt_r.shreg = byte_in;
                nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
                if (r_ff.state == ST_READ) begin
                    nxt_r.tx = {r_ff.tx[6:0], 1'b0};
                end
                if (r_ff.bitcnt == BITS_PER_BYTE - 4'h1) begin
                    unique case (r_ff.state)
                        ST_ADDR: begin
                            if (byte_in[7:1] == TARGET_ADDR) begin
                                nxt_r.ack_pending = 1'b1;
                                if (byte_in[0]) begin
                                    nxt_r.state = ST_READ;
                                    nxt_r.tx = read_val;
                                end else begin
                                    nxt_r.state = ST_INDEX;
                                end
                            end else begin
                                nxt_r.state = ST_IGNORE;
                            end
                        end
                        ST_INDEX: begin
                            nxt_r.index = byte_in;
                            nxt_r.ack_pending = 1'b1;
                            nxt_r.state = ST_DATA;
                        end
                        ST_DATA: begin
                            nxt_r.ack_pending = 1'b1;
                            unique case (r_ff.index)
                                IDX_GENERAL: nxt_r.gc = byte_in;
                                IDX_MAIN: nxt_r.mb = byte_in;
                                IDX_AUX: nxt_r.ab = byte_in;
                                default: nxt_r.shreg = byte_in;
                            endcase
                        end
                        default: nxt_r.shreg = byte_in;
                    endcase
                end
            end else begin
                // ninth bit: the acknowledge slot
                nxt_r.bitcnt = 4'h0;
                if (r_ff.state == ST_READ) begin
                    if (bit_now) begin
                        nxt_r.state = ST_IGNORE;
                    end else begin
                        nxt_r.tx = read_val;
                    end
                end
            end
        end

        // drive changes only after scl has fallen
        if (scl_fall) begin
            if (r_ff.ack_pending) begin
                nxt_r.oe = 1'b1;
                nxt_r.ack_pending = 1'b0;
            end else if (r_ff.state == ST_READ && r_ff.bitcnt < BITS_PER_BYTE) begin
                nxt_r.oe = !r_ff.tx[7];
            end else begin
                nxt_r.oe = 1'b0;
            end
        end

        if (start_evt) begin
            nxt_r.state = ST_ADDR;
            nxt_r.bitcnt = 4'h0;
            nxt_r.ack_pending = 1'b0;
            nxt_r.oe = 1'b0;
        end else if (stop_evt) begin
            nxt_r.state = ST_IDLE;
            nxt_r.ack_pending = 1'b0;
            nxt_r.oe = 1'b0;
        end

        // pwm: on while count*16 < duty*period
        mapped = main_map(r_ff.mb[MAIN_CODE_W-1:0]);
        if (r_ff.pwm_cnt == PW'(PWM_PERIOD - 1)) begin
            nxt_r.pwm_cnt = '0;
        end else begin
            nxt_r.pwm_cnt = r_ff.pwm_cnt + PW'(1);
        end
        nxt_r.pwm_on = (int'(r_ff.pwm_cnt) * DUTY_STEPS) < (int'(mapped[4:0]) * PWM_PERIOD);
        // registered so the level pins never see decoder glitches
        nxt_r.cur_sel = mapped[6:5];

        // fifth sink joins monitoring only with its sense bit; aux never does
        monitored = r_ff.hr_s2 & {r_ff.gc[GC_SENSE5_BIT], {(NUM_MAIN_SINKS-1){1'b1}}};
        monitored = monitored & {NUM_MAIN_SINKS{r_ff.gc[GC_MAIN_EN_BIT]}};
        // no hysteresis figure given: stay at 1.5x until the bank is disabled
        if (!r_ff.gc[GC_MAIN_EN_BIT]) begin
            nxt_r.gain_high = 1'b0;
        end else if (|monitored) begin
            nxt_r.gain_high = 1'b1;
        end

        if (!hw_ok) begin
            nxt_r.gc = GENERAL_RST;
            nxt_r.mb = MAIN_RST;
            nxt_r.ab = AUX_RST;
            nxt_r.state = ST_IDLE;
            nxt_r.ack_pending = 1'b0;
            nxt_r.oe = 1'b0;
            nxt_r.gain_high = 1'b0;
            nxt_r.index = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_ff <= ST_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = r_ff.oe;
    assign bus_busy = r_ff.state != ST_IDLE;
    assign main_sink_on = {NUM_MAIN_SINKS{r_ff.gc[GC_MAIN_EN_BIT] && r_ff.pwm_on}};
    assign main_current_sel = r_ff.cur_sel;
    assign aux_sink_on = r_ff.gc[GC_AUX_EN_BIT];
    assign aux_current_sel = r_ff.ab[AUX_CODE_W-1:0];
    assign pump_gain_high = r_ff.gain_high;
    assign test_bit_zero = r_ff.gc[GC_TEST0_BIT];
    assign test_bit_one = r_ff.gc[GC_TEST1_BIT];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_ack_due;
        scl_fall && r_ff.ack_pending && hw_ok;
    endsequence

    property p_start_restart;
        start_evt |=> r_ff.state == ST_ADDR && r_ff.bitcnt == 4'h0 && !sda_oe;
    endproperty
    a_start_restart: assert property (p_start_restart) else $error("start did not restart");

    property p_free_after_stop;
        stop_evt && !start_evt |=> !bus_busy;
    endproperty
    a_free_after_stop: assert property (p_free_after_stop) else $error("bus busy after stop");

    property p_ack_drive;
        s_ack_due ##1 (!scl_fall && !start_evt && !stop_evt && hw_ok)[*3] |-> sda_oe;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("ack not held low");

    property p_ignore_released;
        r_ff.state == ST_IGNORE && $past(r_ff.state) == ST_IGNORE |-> !sda_oe;
    endproperty
    a_ignore_released: assert property (p_ignore_released) else $error("drove line while ignored");

    property p_hw_reset;
        !hw_ok |=> r_ff.gc == GENERAL_RST && r_ff.mb == MAIN_RST && r_ff.ab == AUX_RST
            && main_sink_on == '0 && !aux_sink_on;
    endproperty
    a_hw_reset: assert property (p_hw_reset) else $error("hardware reset not applied");

    property p_pwm_wrap;
        r_ff.pwm_cnt == PW'(PWM_PERIOD - 1) |=> r_ff.pwm_cnt == '0 ##1 r_ff.pwm_cnt == PW'(1);
    endproperty
    a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm period wrong");

    property p_gain_up;
        hw_ok && r_ff.gc[GC_MAIN_EN_BIT] && (|r_ff.hr_s2[NUM_MAIN_SINKS-2:0]) |=> pump_gain_high;
    endproperty
    a_gain_up: assert property (p_gain_up) else $error("gain did not rise");

    property p_data_write;
        bit_evt && hw_ok && !start_evt && r_ff.state == ST_DATA && r_ff.bitcnt == 4'h7
            && r_ff.index == IDX_MAIN |=> r_ff.mb == $past(byte_in);
    endproperty
    a_data_write: assert property (p_data_write) else $error("write not stored");

    property p_full_duty;
        r_ff.mb[MAIN_CODE_W-1:0] == 5'h1f && $stable(r_ff.mb) && r_ff.gc[GC_MAIN_EN_BIT]
            |-> main_sink_on == '1;
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("full scale not always on");
endmodule
`default_nettype wire

// File: bench/bus_ctrl_model.sv
// Purpose: behavioural two-wire bus controller facing the serial target
// Assumes: open-drain data line with pull-up, resolved in the bench
// Notes: scl idles high between frames; half periods exceed the crossing delay
`timescale 1ns/100ps
`default_nettype none
module bus_ctrl_model #(
    parameter int HALF_NS = 803,
    parameter int QTR_NS = 401
) (
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // start or repeated start: data falls while scl high
    task automatic start_cond();
        if (scl === 1'b0) begin
            #QTR_NS sda_pull = 1'b0;
            #QTR_NS scl = 1'b1;
            #HALF_NS;
        end
        sda_pull = 1'b1;
        #HALF_NS scl = 1'b0;
    endtask

    // data rises while scl high
    task automatic stop_cond();
        #QTR_NS sda_pull = 1'b1;
        #QTR_NS scl = 1'b1;
        #HALF_NS sda_pull = 1'b0;
        #HALF_NS;
    endtask

    // data moves only while scl is low
    task automatic pulse(input logic pull, output logic seen);
        #QTR_NS sda_pull = pull;
        #QTR_NS scl = 1'b1;
        seen = sda;
        #HALF_NS scl = 1'b0;
    endtask

    // eight bits msb first, line released for the ack pulse
    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) pulse(!b[i], s);
        pulse(1'b0, s);
        acked = !s;
    endtask

    // pull_ack low ends a read with a nack
    task automatic recv_byte(input logic pull_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b0, s);
            b[i] = s;
        end
        pulse(pull_ack, s);
    endtask
endmodule
`default_nettype wire

// File: bench/led_driver_serial_control_tb_top.sv
// Purpose: self-checking bench for the led driver serial control block
// Assumes: bus controller model on the serial pins, pull-up on the data line
// Notes: short pwm period so one window is sixteen clk cycles
`timescale 1ns/100ps
`default_nettype none
module led_driver_serial_control_tb_top import led_pkg::*; ;
    // arbitrary value, not any real part's address
    localparam logic [6:0] ADDR = 7'h2a;
    localparam int PWM_N = 16;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hw_reset_n = 1'b1;
    logic [4:0] headroom_low = 5'h00;
    logic scl, sda_pull, sda_out, sda_oe, aux_sink_on, pump_gain_high, bus_busy, tb0, tb1;
    logic [4:0] main_sink_on;
    logic [1:0] main_current_sel, aux_current_sel;
    wire logic sda_line;
    int fails = 0;
    int checked = 0;

    assign sda_line = (sda_oe ? sda_out : 1'b1) & !sda_pull;
    always #50 clk = ~clk;

    led_driver_serial_control #(.TARGET_ADDR(ADDR), .PWM_PERIOD(PWM_N))
    led_driver_serial_control_inst (
        .clk(clk), .rstn(rstn), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .hw_reset_n(hw_reset_n), .headroom_low(headroom_low),
        .main_sink_on(main_sink_on), .main_current_sel(main_current_sel),
        .aux_sink_on(aux_sink_on), .aux_current_sel(aux_current_sel),
        .pump_gain_high(pump_gain_high), .bus_busy(bus_busy),
        .test_bit_zero(tb0), .test_bit_one(tb1)
    );
    bus_ctrl_model bus_ctrl_model_inst (.sda(sda_line), .scl(scl), .sda_pull(sda_pull));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic end_test(input string name);
        $display("test %s done, %0d checks, %0d mismatches", name, checked, fails);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
                      input logic exp_ack);
        logic ak;
        bus_ctrl_model_inst.start_cond();
        bus_ctrl_model_inst.send_byte({a, 1'b0}, ak);
        check("address ack", {7'h00, ak}, {7'h00, exp_ack});
        check("bus busy", {7'h00, bus_busy}, 8'h01);
        bus_ctrl_model_inst.send_byte(idx, ak);
        check("index ack", {7'h00, ak}, {7'h00, exp_ack});
        if (exp_ack === 1'b1) begin
            bus_ctrl_model_inst.send_byte(d, ak);
            check("data ack", {7'h00, ak}, 8'h01);
        end
        bus_ctrl_model_inst.stop_cond();
        repeat (5) @(negedge clk);
        check("bus free", {7'h00, bus_busy}, 8'h00);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic ak;
        logic [7:0] d;
        logic [7:0] d2;
        bus_ctrl_model_inst.start_cond();
        bus_ctrl_model_inst.send_byte({ADDR, 1'b0}, ak);
        bus_ctrl_model_inst.send_byte(idx, ak);
        bus_ctrl_model_inst.start_cond();
        bus_ctrl_model_inst.send_byte({ADDR, 1'b1}, ak);
        check("read ack", {7'h00, ak}, 8'h01);
        // acked first byte keeps the read going on the same register
        bus_ctrl_model_inst.recv_byte(1'b1, d);
        bus_ctrl_model_inst.recv_byte(1'b0, d2);
        bus_ctrl_model_inst.stop_cond();
        repeat (2) @(negedge clk);
        check(what, d, exp);
        check(what, d2, exp);
    endtask

    function automatic int duty_of(input logic [4:0] c);
        if (c < 5'h10) return c + 1;
        if (c < 5'h17) return c - 6;
        if (c < 5'h1d) return c - 12;
        return (c == 5'h1d) ? 13 : (c == 5'h1e) ? 15 : 16;
    endfunction

    function automatic logic [1:0] cur_of(input logic [4:0] c);
        return (c < 5'h10) ? CUR_20 : (c < 5'h17) ? CUR_40 : (c < 5'h1d) ? CUR_70 : CUR_100;
    endfunction

    initial begin
        logic [7:0] g, m, x;
        int on;
        void'($urandom(94587));
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
        check("gain after reset", {7'h00, pump_gain_high}, 8'h00);
        check("main after reset", {3'h0, main_sink_on}, 8'h00);
        rd_chk("general reset", IDX_GENERAL, GENERAL_RST);
        rd_chk("main reset", IDX_MAIN, MAIN_RST);
        rd_chk("aux reset", IDX_AUX, AUX_RST);
        end_test("reset values");
        for (int i = 0; i < 4; i++) begin
            g = 8'($urandom()) & 8'hbd; // controller keeps test bits clear
            m = 8'($urandom());
            x = {6'($urandom()), 2'(i)};
            wr(ADDR, IDX_GENERAL, g, 1'b1);
            wr(ADDR, IDX_MAIN, m, 1'b1);
            wr(ADDR, IDX_AUX, x, 1'b1);
            rd_chk("general", IDX_GENERAL, g);
            rd_chk("main", IDX_MAIN, m);
            rd_chk("aux", IDX_AUX, x);
            check("aux on", {7'h00, aux_sink_on}, {7'h00, g[GC_AUX_EN_BIT]});
            check("aux level", {6'h00, aux_current_sel}, 8'(i));
            check("main level", {6'h00, main_current_sel}, {6'h00, cur_of(m[4:0])});
            check("test zero", {7'h00, tb0}, 8'h00);
            check("test one", {7'h00, tb1}, 8'h00);
        end
        end_test("register access");
        wr(ADDR ^ 7'h01, IDX_AUX, 8'h55, 1'b0);
        rd_chk("aux untouched", IDX_AUX, x);
        wr(ADDR, 8'h33, 8'h77, 1'b1);
        rd_chk("unmapped", 8'h33, UNMAPPED_READ);
        end_test("addressing");
        wr(ADDR, IDX_GENERAL, 8'h01, 1'b1);
        for (int c = 0; c < 32; c++) begin
            wr(ADDR, IDX_MAIN, 8'(c) | 8'he0, 1'b1);
            on = 0;
            repeat (PWM_N) begin
                @(negedge clk);
                on += int'(main_sink_on[0] === 1'b1);
            end
            check("duty", 8'(on), 8'(duty_of(5'(c))));
            check("current", {6'h00, main_current_sel}, {6'h00, cur_of(5'(c))});
        end
        end_test("brightness");
        headroom_low = 5'h10;
        repeat (6) @(negedge clk);
        check("fifth ignored", {7'h00, pump_gain_high}, 8'h00);
        wr(ADDR, IDX_GENERAL, 8'h21, 1'b1);
        check("fifth sensed", {7'h00, pump_gain_high}, 8'h01);
        headroom_low = 5'h00;
        wr(ADDR, IDX_GENERAL, 8'h04, 1'b1);
        check("main off", {3'h0, main_sink_on}, 8'h00);
        headroom_low = 5'(1 << ($urandom() % 4));
        repeat (6) @(negedge clk);
        check("gain idle", {7'h00, pump_gain_high}, 8'h00);
        wr(ADDR, IDX_GENERAL, 8'h05, 1'b1);
        check("gain raised", {7'h00, pump_gain_high}, 8'h01);
        end_test("pump gain");
        headroom_low = 5'h00;
        hw_reset_n = 1'b0;
        repeat (4) @(negedge clk);
        check("sinks in reset", {3'h0, main_sink_on}, 8'h00);
        check("gain in reset", {7'h00, pump_gain_high}, 8'h00);
        hw_reset_n = 1'b1; // held high in normal running
        repeat (6) @(negedge clk);
        check("aux after reset", {7'h00, aux_sink_on}, 8'h00);
        rd_chk("general restored", IDX_GENERAL, GENERAL_RST);
        rd_chk("main restored", IDX_MAIN, MAIN_RST);
        rd_chk("aux restored", IDX_AUX, AUX_RST);
        end_test("hardware reset");
        complete_run();
    end

    // whole run takes about 4 ms of bus traffic
    initial begin
        #(6_000_000);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
